// ===== assembly_pkg.sv
// Purpose: shared constants for the cyclic output assembly link
// Assumes: one byte per link beat, frames closed by a last flag
// Notes:   offsets are byte positions inside one assembly
package assembly_pkg;
	localparam int               BYTE_W        = 8;
	localparam int               POS_W         = 9;
	localparam int               FIFO_DEPTH    = 8;
	// assembly lengths, both layouts
	localparam logic [8:0]       MIN_LEN       = 9'h001;
	localparam logic [8:0]       FULL_MAX_LEN  = 9'h107;  // 263
	localparam logic [8:0]       RED_MAX_LEN   = 9'h106;  // 262
	localparam logic [8:0]       MAX_ENTRY_IDX = 9'h0fe;  // 254
	// byte offsets, full layout
	localparam logic [8:0]       OFS_CTRL      = 9'h000;
	localparam logic [8:0]       OFS_F_IO      = 9'h001;
	localparam logic [8:0]       OFS_F_FNUM    = 9'h002;
	localparam logic [8:0]       OFS_F_FREM    = 9'h003;
	localparam logic [8:0]       OFS_F_FSIZE   = 9'h004;
	localparam logic [8:0]       OFS_F_FLAGS   = 9'h005;
	localparam logic [8:0]       OFS_F_LENLO   = 9'h006;
	localparam logic [8:0]       OFS_F_LENHI   = 9'h007;
	localparam logic [8:0]       OFS_F_DATA    = 9'h008;
	// byte offsets, reduced layout
	localparam logic [8:0]       OFS_R_FNUM    = 9'h001;
	localparam logic [8:0]       OFS_R_FREM    = 9'h002;
	localparam logic [8:0]       OFS_R_FSIZE   = 9'h003;
	localparam logic [8:0]       OFS_R_FLAGS   = 9'h004;
	localparam logic [8:0]       OFS_R_LENLO   = 9'h005;
	localparam logic [8:0]       OFS_R_LENHI   = 9'h006;
	localparam logic [8:0]       OFS_R_DATA    = 9'h007;
	// control byte bits
	localparam int               CTRL_ACT      = 0;
	localparam int               CTRL_ACK      = 1;
	localparam int               CTRL_DRESET   = 2;
	localparam int               CTRL_ERRACK   = 3;
	localparam int               CTRL_STANDBY  = 4;
	// monitoring byte bits: output n at 2n, counter reset n at 2n+1
	localparam int               IO_SW0        = 0;
	localparam int               IO_RST0       = 1;
	// flags byte bits
	localparam int               FLAG_NEWDATA  = 5;
	localparam int               FLAG_TOGGLE   = 6;
	// controller register map (apb byte addresses)
	localparam logic [11:0]      ADDR_CFG      = 12'h000;
	localparam logic [11:0]      ADDR_DATA     = 12'h004;
	localparam logic [11:0]      ADDR_STATUS   = 12'h008;
	localparam int               CFG_LAYOUT    = 0;
	localparam int               CFG_LEN_LSB   = 16;
	localparam logic             RST_LAYOUT    = 1'b1;
	localparam logic [8:0]       RST_LEN       = 9'h001;
	typedef enum logic [0:0] {
		TX_IDLE  = 1'b0,
		TX_FRAME = 1'b1
	} tx_state_t;
endpackage

// ===== assembly_if.sv
// Purpose: byte link from controller end to reader end
// Assumes: both ends on pclk
// Notes:   layout_full is a level fixed while a frame is open
`timescale 1ns/100ps
interface assembly_if;
	logic       valid;
	logic       ready;
	logic [7:0] data;
	logic       last;
	logic       layout_full;
	modport ctrl_end   (output valid, output data, output last, output layout_full, input ready);
	modport reader_end (input valid, input data, input last, input layout_full, output ready);
endinterface

// ===== assembly_ctrl_end.sv
// Purpose: controller end, apb registers to framed byte stream
// Assumes: software writes config, then the assembly bytes in order
// Notes:   data writes stall on pready while the fifo is full
`timescale 1ns/100ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             wvalid,
	output logic                  wready,
	input  wire logic [WIDTH-1:0] wdata,
	output logic                  rvalid,
	input  wire logic             rready,
	output logic      [WIDTH-1:0] rdata
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wptr_r;
	logic [AW:0]      rptr_r;
	// extra pointer bit tells full from empty
	assign rvalid = (wptr_r != rptr_r);
	assign wready = (wptr_r[AW-1:0] != rptr_r[AW-1:0]) || (wptr_r[AW] == rptr_r[AW]);
	assign rdata  = mem[rptr_r[AW-1:0]];
	always_ff @(posedge pclk) begin
		if (wvalid && wready) begin
			mem[wptr_r[AW-1:0]] <= wdata;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr_r <= '0;
			rptr_r <= '0;
		end else begin
			if (wvalid && wready) wptr_r <= wptr_r + 1'b1;
			if (rvalid && rready) rptr_r <= rptr_r + 1'b1;
		end
	end
endmodule

module assembly_ctrl_end #(
	parameter int DEPTH = assembly_pkg::FIFO_DEPTH
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	assembly_if.ctrl_end     link
);
	logic                   layout_r;
	logic [8:0]             len_r;
	logic [8:0]             idx_r;
	logic [15:0]            frames_r;
	assembly_pkg::tx_state_t state_r;
	logic                   lvalid_r;
	logic [7:0]             ldata_r;
	logic                   llast_r;
	logic                   pready_r;
	logic                   pslverr_r;
	logic [31:0]            prdata_r;
	logic                   f_wready;
	logic                   f_rvalid;
	logic [7:0]             f_rdata;
	logic                   cfg_ok;
	logic                   load;
	logic                   done;
	logic                   is_data;
	logic                   mapped;
	// lengths outside the layout's span are refused by holding the stream
	assign cfg_ok  = (len_r >= assembly_pkg::MIN_LEN) &&
	                 (len_r <= (layout_r ? assembly_pkg::FULL_MAX_LEN
	                                     : assembly_pkg::RED_MAX_LEN)); // R02 R13
	assign load    = f_rvalid && cfg_ok && (!lvalid_r || link.ready);
	assign done    = psel && penable && pready_r;
	assign is_data = (paddr == assembly_pkg::ADDR_DATA);
	assign mapped  = (paddr == assembly_pkg::ADDR_CFG) || is_data ||
	                 (paddr == assembly_pkg::ADDR_STATUS);
	byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
		.pclk    (pclk),
		.presetn (presetn),
		.wvalid  (done && pwrite && is_data),
		.wready  (f_wready),
		.wdata   (pwdata[7:0]),
		.rvalid  (f_rvalid),
		.rready  (load),
		.rdata   (f_rdata)
	);
	// apb answer: one wait state, more while a data write meets a full fifo
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= '0;
		end else begin
			pready_r  <= psel && penable && !pready_r && (!(pwrite && is_data) || f_wready);
			pslverr_r <= psel && penable && !pready_r && !mapped;
			if (paddr == assembly_pkg::ADDR_CFG)
				prdata_r <= {7'h00, len_r, 15'h0000, layout_r};
			else if (paddr == assembly_pkg::ADDR_STATUS)
				prdata_r <= {frames_r, 12'h000, cfg_ok, state_r, f_rvalid, !f_wready};
			else
				prdata_r <= '0;
		end
	end
	// config is frozen while a frame is open, so the reader sees one layout;
	// a last byte still held by a stalled reader counts as open, else it
	// would be decoded with the new layout's offsets
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			layout_r <= assembly_pkg::RST_LAYOUT;
			len_r    <= assembly_pkg::RST_LEN;
		end else if (done && pwrite && (paddr == assembly_pkg::ADDR_CFG) &&
		             state_r == assembly_pkg::TX_IDLE && !(lvalid_r && llast_r)) begin
			layout_r <= pwdata[assembly_pkg::CFG_LAYOUT]; // R01
			len_r    <= pwdata[assembly_pkg::CFG_LEN_LSB +: 9]; // R10
		end
	end
	// output stage: link signals straight from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvalid_r <= 1'b0;
			ldata_r  <= '0;
			llast_r  <= 1'b0;
			idx_r    <= '0;
			frames_r <= '0;
			state_r  <= assembly_pkg::TX_IDLE;
		end else if (load) begin
			lvalid_r <= 1'b1;
			ldata_r  <= f_rdata;
			llast_r  <= (idx_r == len_r - 9'h001); // R11
			if (idx_r == len_r - 9'h001) begin
				idx_r    <= '0;
				frames_r <= frames_r + 16'h0001;
				state_r  <= assembly_pkg::TX_IDLE;
			end else begin
				idx_r   <= idx_r + 9'h001;
				state_r <= assembly_pkg::TX_FRAME;
			end
		end else if (link.ready) begin
			lvalid_r <= 1'b0;
		end
	end
	assign link.valid       = lvalid_r;
	assign link.data        = ldata_r;
	assign link.last        = llast_r;
	assign link.layout_full = layout_r;
	assign prdata           = prdata_r;
	assign pready           = pready_r;
	assign pslverr          = pslverr_r;
endmodule

// ===== assembly_reader_end.sv
// Purpose: reader end, decodes cyclic output assemblies from the link
// Assumes: link is on pclk; frames end on link.last
// Notes:   fields not reached before last keep their old value
// Contract
// R01: controller sends full or reduced layout cyclically
// R02: full layout 1..263 bytes, decode present only
// R03: byte 0 holds five control bits
// R04: full byte 1 holds output and counter bits
// R05: output bit acts only if external-event configured
// R06: full layout fragment fields in bytes 2-4
// R07: reduced layout fragment fields in bytes 1-3
// R08: full entry length bytes 6 low, 7 high
// R09: full entry data from byte 8, up to 255
// R10: controller length is eight plus entry length
// R11: one-byte assembly carries only control byte
// R12: two-byte full assembly adds monitoring byte
// R13: reduced layout 1..262 bytes
// R14: reduced length bytes 5,6; data from 7
// R15: toggle change means new entry; flag valid
// R16: reserved bits are ignored
`timescale 1ns/100ps
module assembly_reader_end #(
	parameter int NOUT = 2
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	assembly_if.reader_end       link,
	input  wire logic            accept,
	input  wire logic [NOUT-1:0] ext_event_en,
	output logic                 activation,
	output logic                 data_ack,
	output logic                 data_reset,
	output logic                 error_ack,
	output logic                 standby_req,
	output logic      [NOUT-1:0] sw_out,
	output logic      [NOUT-1:0] cnt_reset,
	output logic                 io_present,
	output logic      [7:0]      frag_num,
	output logic      [7:0]      frag_rem,
	output logic      [7:0]      frag_size,
	output logic                 frag_present,
	output logic                 new_data,
	output logic                 new_entry,
	output logic      [15:0]     entry_len,
	output logic                 len_present,
	output logic      [7:0]      entry_byte,
	output logic      [7:0]      entry_idx,
	output logic                 entry_valid,
	output logic                 frame_done,
	output logic      [8:0]      frame_len
);
	logic [8:0]      pos_r;
	logic            ready_r;
	logic [4:0]      ctrl_r;
	logic [NOUT-1:0] sw_req_r;
	logic [NOUT-1:0] sw_out_r;
	logic [NOUT-1:0] cnt_reset_r;
	logic            io_pres_r;
	logic [7:0]      fnum_r;
	logic [7:0]      frem_r;
	logic [7:0]      fsize_r;
	logic            frag_pres_r;
	logic            new_data_r;
	logic            toggle_r;
	logic            new_entry_r;
	logic [15:0]     elen_r;
	logic            len_pres_r;
	logic [7:0]      ebyte_r;
	logic [7:0]      eidx_r;
	logic            evalid_r;
	logic            done_r;
	logic [8:0]      flen_r;
	logic            fire;
	logic            full;
	logic [8:0]      off_fnum;
	logic [8:0]      off_frem;
	logic [8:0]      off_fsize;
	logic [8:0]      off_flags;
	logic [8:0]      off_lenlo;
	logic [8:0]      off_lenhi;
	logic [8:0]      off_data;
	logic [8:0]      dpos;
	logic [8:0]      max_len;
	logic            in_span;
	// the layout picks every field offset after the control byte; reduced drops the monitoring byte
	assign full      = link.layout_full; // R01
	assign off_fnum  = full ? assembly_pkg::OFS_F_FNUM  : assembly_pkg::OFS_R_FNUM;  // R06 R07
	assign off_frem  = full ? assembly_pkg::OFS_F_FREM  : assembly_pkg::OFS_R_FREM;  // R06 R07
	assign off_fsize = full ? assembly_pkg::OFS_F_FSIZE : assembly_pkg::OFS_R_FSIZE; // R06 R07
	assign off_flags = full ? assembly_pkg::OFS_F_FLAGS : assembly_pkg::OFS_R_FLAGS;
	assign off_lenlo = full ? assembly_pkg::OFS_F_LENLO : assembly_pkg::OFS_R_LENLO; // R08 R14
	assign off_lenhi = full ? assembly_pkg::OFS_F_LENHI : assembly_pkg::OFS_R_LENHI; // R08 R14
	assign off_data  = full ? assembly_pkg::OFS_F_DATA  : assembly_pkg::OFS_R_DATA;  // R09 R14
	assign max_len   = full ? assembly_pkg::FULL_MAX_LEN : assembly_pkg::RED_MAX_LEN;
	assign fire      = link.valid && ready_r;
	assign dpos      = pos_r - off_data;
	// bytes past the layout's maximum are dropped rather than decoded
	assign in_span   = (pos_r < max_len); // R02 R13

	// link ready follows the user's accept one cycle late
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ready_r <= 1'b0;
		else          ready_r <= accept;
	end

	// byte position inside the frame; saturates on overlong frames
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_r  <= '0;
			done_r <= 1'b0;
			flen_r <= '0;
		end else begin
			done_r <= fire && link.last;
			if (fire && link.last) begin
				pos_r  <= '0;
				flen_r <= in_span ? pos_r + 9'h001 : max_len; // R02 R13
			end else if (fire && pos_r != 9'h1ff) begin
				pos_r <= pos_r + 9'h001;
			end
		end
	end

	// control byte; bits 5..7 never looked at
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= '0;
		end else if (fire && pos_r == assembly_pkg::OFS_CTRL) begin
			ctrl_r[0] <= link.data[assembly_pkg::CTRL_ACT];     // R03
			ctrl_r[1] <= link.data[assembly_pkg::CTRL_ACK];     // R03
			ctrl_r[2] <= link.data[assembly_pkg::CTRL_DRESET];  // R03
			ctrl_r[3] <= link.data[assembly_pkg::CTRL_ERRACK];  // R03
			ctrl_r[4] <= link.data[assembly_pkg::CTRL_STANDBY]; // R03 R16
		end
	end

	// presence flags: rebuilt each frame from the bytes actually seen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_pres_r   <= 1'b0;
			frag_pres_r <= 1'b0;
			len_pres_r  <= 1'b0;
		end else if (fire && pos_r == assembly_pkg::OFS_CTRL) begin
			io_pres_r   <= 1'b0; // R11
			frag_pres_r <= 1'b0; // R11
			len_pres_r  <= 1'b0; // R11
		end else if (fire) begin
			if (full && pos_r == assembly_pkg::OFS_F_IO) io_pres_r <= 1'b1; // R12
			if (pos_r == off_fsize) frag_pres_r <= 1'b1;
			if (pos_r == off_lenhi) len_pres_r <= 1'b1;
		end
	end

	// per switching output: request, gated output, counter reset pulse
	genvar gi;
	generate
		for (gi = 0; gi < NOUT; gi++) begin : g_out
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sw_req_r[gi]    <= 1'b0;
					sw_out_r[gi]    <= 1'b0;
					cnt_reset_r[gi] <= 1'b0;
				end else begin
					cnt_reset_r[gi] <= fire && full && pos_r == assembly_pkg::OFS_F_IO &&
					                   link.data[assembly_pkg::IO_RST0 + 2*gi]; // R04
					if (fire && full && pos_r == assembly_pkg::OFS_F_IO)
						sw_req_r[gi] <= link.data[assembly_pkg::IO_SW0 + 2*gi]; // R04 R16
					// without the external-event function the request has no effect
					sw_out_r[gi] <= sw_req_r[gi] && ext_event_en[gi]; // R05
				end
			end
		end
	endgenerate

	// fragment fields and entry length
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fnum_r  <= '0;
			frem_r  <= '0;
			fsize_r <= '0;
			elen_r  <= '0;
		end else if (fire) begin
			if (pos_r == off_fnum)  fnum_r  <= link.data; // R06 R07
			if (pos_r == off_frem)  frem_r  <= link.data; // R06 R07
			if (pos_r == off_fsize) fsize_r <= link.data; // R06 R07
			if (pos_r == off_lenlo) elen_r[7:0]  <= link.data; // R08 R14
			if (pos_r == off_lenhi) elen_r[15:8] <= link.data; // R08 R14
		end
	end

	// flags byte: a change of the toggle marks a new entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			toggle_r    <= 1'b0;
			new_data_r  <= 1'b0;
			new_entry_r <= 1'b0;
		end else begin
			new_entry_r <= fire && pos_r == off_flags &&
			               (link.data[assembly_pkg::FLAG_TOGGLE] != toggle_r); // R15
			if (fire && pos_r == off_flags) begin
				toggle_r   <= link.data[assembly_pkg::FLAG_TOGGLE];  // R15
				new_data_r <= link.data[assembly_pkg::FLAG_NEWDATA]; // R15 R16
			end
		end
	end

	// entry data stream; count set by where the frame ends, at most 255 bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evalid_r <= 1'b0;
			ebyte_r  <= '0;
			eidx_r   <= '0;
		end else begin
			evalid_r <= fire && pos_r >= off_data &&
			            dpos <= assembly_pkg::MAX_ENTRY_IDX; // R09 R14
			if (fire && pos_r >= off_data && dpos <= assembly_pkg::MAX_ENTRY_IDX) begin
				ebyte_r <= link.data;
				eidx_r  <= dpos[7:0]; // R09
			end
		end
	end

	assign link.ready   = ready_r;
	assign activation   = ctrl_r[0];
	assign data_ack     = ctrl_r[1];
	assign data_reset   = ctrl_r[2];
	assign error_ack    = ctrl_r[3];
	assign standby_req  = ctrl_r[4];
	assign sw_out       = sw_out_r;
	assign cnt_reset    = cnt_reset_r;
	assign io_present   = io_pres_r;
	assign frag_num     = fnum_r;
	assign frag_rem     = frem_r;
	assign frag_size    = fsize_r;
	assign frag_present = frag_pres_r;
	assign new_data     = new_data_r;
	assign new_entry    = new_entry_r;
	assign entry_len    = elen_r;
	assign len_present  = len_pres_r;
	assign entry_byte   = ebyte_r;
	assign entry_idx    = eidx_r;
	assign entry_valid  = evalid_r;
	assign frame_done   = done_r;
	assign frame_len    = flen_r;
endmodule

// ===== assembly_link_monitor.sv
// Purpose: watches the byte link between the controller and reader ends
// Assumes: one pclk domain, reset active low
// Notes:   frame byte count is rebuilt here from the handshake alone
`timescale 1ns/100ps
module assembly_link_monitor (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       valid,
	input  wire logic       ready,
	input  wire logic [7:0] data,
	input  wire logic       last,
	input  wire logic       layout_full
);
	logic [8:0] cnt_r;
	logic       open_r;
	logic       lay_r;

	default clocking dck @(posedge pclk); endclocking
	default disable iff (!presetn);

	// bytes taken so far in the open frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r  <= 9'h000;
			open_r <= 1'b0;
		end else if (valid && ready) begin
			cnt_r  <= last ? 9'h000 : cnt_r + 9'h001;
			open_r <= !last;
		end
	end

	// layout seen with the first byte, so a late switch is caught at the last
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lay_r <= 1'b1;
		end else if (valid && ready && !open_r) begin
			lay_r <= layout_full;
		end
	end

	chk_valid_hold: assert property (valid && !ready |=> valid)
		else $error("link valid dropped before taken");
	chk_data_hold: assert property (valid && !ready |=> $stable(data))
		else $error("link data changed before taken");
	chk_last_hold: assert property (valid && !ready |=> $stable(last))
		else $error("link last changed before taken");
	chk_layout_frozen: assert property (open_r |-> $stable(layout_full))
		else $error("layout changed inside a frame");
	chk_layout_whole: assert property (valid && ready && last && open_r |-> layout_full == lay_r)
		else $error("frame ended in another layout");
	chk_full_max: assert property (valid && ready && last && layout_full |-> cnt_r < assembly_pkg::FULL_MAX_LEN)
		else $error("full frame longer than 263 bytes");
	chk_reduced_max: assert property (valid && ready && last && !layout_full |-> cnt_r < assembly_pkg::RED_MAX_LEN)
		else $error("reduced frame longer than 262 bytes");
	chk_reset_idle: assert property ($rose(presetn) |-> !valid && layout_full)
		else $error("link not idle after reset");
endmodule

// ===== cyclic_output_assembly_decoder_tb_top.sv
// Purpose: drives the controller end over apb and checks the reader end
// Assumes: reader accepts bytes unless a scenario stalls it
// Notes:   expected fields come from the layout offsets only
`timescale 1ns/100ps
module cyclic_output_assembly_decoder_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, accept, wdone;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [1:0]  ext_event_en, sw_out, cnt_reset, cnt_seen;
	logic        activation, data_ack, data_reset, error_ack, standby_req;
	logic        io_present, frag_present, len_present, new_data, new_entry;
	logic        entry_valid, frame_done;
	logic [7:0]  frag_num, frag_rem, frag_size, entry_byte, entry_idx;
	logic [15:0] entry_len;
	logic [8:0]  frame_len;
	logic [7:0]  fb [$];
	logic [15:0] ent_q [$];
	int          miscompares, num_checks, done_cnt, ne_cnt, cyc, frames_exp;

	assembly_if link_bus ();
	assembly_ctrl_end u_assembly_ctrl_end (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(link_bus));
	assembly_reader_end u_assembly_reader_end (.pclk(pclk), .presetn(presetn), .link(link_bus),
		.accept(accept), .ext_event_en(ext_event_en), .activation(activation),
		.data_ack(data_ack), .data_reset(data_reset), .error_ack(error_ack),
		.standby_req(standby_req), .sw_out(sw_out), .cnt_reset(cnt_reset),
		.io_present(io_present), .frag_num(frag_num), .frag_rem(frag_rem),
		.frag_size(frag_size), .frag_present(frag_present), .new_data(new_data),
		.new_entry(new_entry), .entry_len(entry_len), .len_present(len_present),
		.entry_byte(entry_byte), .entry_idx(entry_idx), .entry_valid(entry_valid),
		.frame_done(frame_done), .frame_len(frame_len));
	assembly_link_monitor u_assembly_link_monitor (.pclk(pclk), .presetn(presetn),
		.valid(link_bus.valid), .ready(link_bus.ready), .data(link_bus.data),
		.last(link_bus.last), .layout_full(link_bus.layout_full));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// pulse counters, captured entry bytes and the hang limit
	always @(posedge pclk) begin
		cyc++;
		if (frame_done === 1'b1) done_cnt++;
		if (new_entry === 1'b1) ne_cnt++;
		if (entry_valid === 1'b1) ent_q.push_back({entry_idx, entry_byte});
		if (cnt_reset !== 2'b00) cnt_seen = cnt_seen | cnt_reset;
		if (cyc == 20000) begin
			miscompares++;
			summarize();
		end
	end

	task automatic summarize();
		if (miscompares == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer; waits on pready with no assumed latency
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	// read data is only meaningful when no error is expected
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		if (!eexp) chk(r, exp);
		chk(e, eexp);
	endtask

	task automatic cfg(input logic full);
		logic [8:0] len;
		len = 9'(fb.size());
		ent_q.delete();
		wr(assembly_pkg::ADDR_CFG, {7'h00, len, 15'h0000, full});
	endtask

	task automatic push(input int n0, input int n1);
		for (int i = n0; i < n1; i++) wr(assembly_pkg::ADDR_DATA, {24'h000000, fb[i]});
	endtask

	// frame_done count is the completion signal; the timeout bounds it
	task automatic wait_done();
		while (done_cnt <= frames_exp) @(posedge pclk);
		@(posedge pclk);
		frames_exp++;
	endtask

	task automatic chk_ent(input int ofs);
		chk(ent_q.size(), fb.size() - ofs);
		for (int i = 0; i < fb.size() - ofs; i++) chk(ent_q[i], {i[7:0], fb[ofs + i]});
	endtask

	task automatic s_regs();
		rd_chk(assembly_pkg::ADDR_CFG, 32'h0001_0001, 1'b0);
		rd_chk(assembly_pkg::ADDR_STATUS, 32'h0000_0008, 1'b0);
		rd_chk(12'h00c, 32'h0000_0000, 1'b1);
	endtask

	// reserved bits set in the control and monitoring bytes; only output zero is enabled for external events
	task automatic s_full();
		fb = {8'hf5, 8'hff, 8'h03, 8'h02, 8'h40, 8'h60, 8'h02, 8'h00, 8'ha5, 8'h5a};
		cfg(1'b1);
		push(0, 10);
		wait_done();
		chk({activation, data_ack, data_reset, error_ack, standby_req}, 5'b10101);
		chk({sw_out, cnt_seen, io_present}, 5'b01111);
		chk({frag_num, frag_rem, frag_size}, 24'h030240);
		chk({entry_len, new_data, frag_present, len_present}, {16'h0002, 3'b111});
		chk(ne_cnt, 1);
		chk_ent(8);
		chk(frame_len, 9'h00a);
	endtask

	task automatic s_reduced();
		fb = {8'h0a, 8'h11, 8'h22, 8'h33, 8'h20, 8'h02, 8'h00, 8'h77, 8'h88};
		cfg(1'b0);
		push(0, 9);
		wait_done();
		chk({activation, data_ack, data_reset, error_ack, standby_req}, 5'b01010);
		chk({frag_num, frag_rem, frag_size}, 24'h112233);
		chk({entry_len, new_data, io_present}, {16'h0002, 2'b10});
		chk(ne_cnt, 2);
		chk_ent(7);
		chk(frame_len, 9'h009);
	endtask

	// one- and two-byte full frames, then an output enabled late
	task automatic s_short();
		fb = {8'h08};
		cfg(1'b1);
		push(0, 1);
		wait_done();
		chk({error_ack, io_present, frag_present, len_present, frame_len}, 13'h1001);
		cnt_seen = 2'b00;
		fb = {8'h10, 8'h0c};
		cfg(1'b1);
		push(0, 2);
		wait_done();
		chk({standby_req, error_ack, io_present, frag_present, sw_out, cnt_seen}, 8'ha2);
		ext_event_en <= 2'b11;
		repeat (2) @(posedge pclk);
		chk(sw_out, 2'b10);
	endtask

	// reader stalls until the fifo refuses a write, then drains
	task automatic s_stall();
		fb = {8'h01, 8'h00, 8'h05, 8'h00, 8'h10, 8'h00, 8'h02, 8'h00, 8'hc3, 8'h3c};
		accept <= 1'b0;
		wdone = 1'b0;
		cfg(1'b1);
		push(0, 8);
		fork
			begin
				push(8, 10);
				wdone = 1'b1;
			end
			begin
				repeat (40) @(posedge pclk);
				chk({wdone, 31'(done_cnt)}, {1'b0, 31'(frames_exp)});
				accept <= 1'b1;
			end
		join
		wait_done();
		chk({ne_cnt[7:0], new_data, activation}, 10'h009);
		chk_ent(8);
		rd_chk(assembly_pkg::ADDR_STATUS, 32'h0005_0008, 1'b0);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		accept = 1'b1;
		ext_event_en = 2'b01;
		cnt_seen = 2'b00;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		s_regs();
		s_full();
		s_reduced();
		s_short();
		s_stall();
		summarize();
	end
endmodule
